// File: bench/dfr_sink.sv
// Byte sink in the place of the host across the transport.
// Assumes stall is driven off the clock edge by the bench.
`timescale 1ns/100ps
module dfr_sink
    import dfr_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         stall,
    input  wire dfr_byte_type tx_q,
    output logic              tx_ready
);
    logic [7:0] q[$];
    int         pkts = 0;
    assign tx_ready = !stall;
    // Bytes kept whole; the bench splits them at the queue size it finds as each packet ends
    always @(posedge core_clk) begin
        if (tx_q.valid && tx_ready) begin
            q.push_back(tx_q.data);
            if (tx_q.last)
                pkts <= pkts + 1;  // Host timeout restarts here
        end
    end
endmodule

// File: bench/tb_top.sv
// Random and corner tests of the framer, sink stalls at random.
// Assumes the sink is the only consumer of tx_q.
`timescale 1ns/100ps
module tb_top
    import dfr_pkg::*;
;
    logic          core_clk, tx_ready, ev_ready_q;
    logic          rst_b = 1'b0, ev_valid = 1'b0, stall = 1'b0, cfg_packed_en = 1'b0, postfix_en = 1'b0;
    logic          cmd_start = 1'b0, cmd_done = 1'b0, rd_req = 1'b0, pend_req = 1'b0;
    logic [15:0]   cmd_tag = '0, pend_timeout_ms = '0, max_resp_ms = 16'h0003, etag = '0;
    logic [31:0]   rd_addr = '0, seed = 32'h8c7c;
    dfr_event_type ev = '0, evs[2];
    dfr_byte_type  tx_q;
    dfr_rd_type    rd_q;
    logic [7:0]    exp[$];
    int            num_errors = 0, checks_done = 0, base = 0, seen = 0;

    dfr_framer #(.MS_CYCLES(4), .MFR_STR(512'h636261), .MFR_LEN(7'h03)) dut (.core_clk(core_clk), .rst_b(rst_b),
        .ce(1'b1), .ev_valid(ev_valid), .ev(ev), .ev_ready_q(ev_ready_q), .tx_q(tx_q), .tx_ready(tx_ready),
        .cfg_packed_en(cfg_packed_en), .postfix_en(postfix_en), .cmd_start(cmd_start), .cmd_tag(cmd_tag),
        .cmd_done(cmd_done), .pend_req(pend_req), .pend_timeout_ms(pend_timeout_ms), .max_resp_ms(max_resp_ms),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_q(rd_q));
    dfr_sink sink (.core_clk(core_clk), .stall(stall), .tx_q(tx_q), .tx_ready(tx_ready));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic void push16(input logic [15:0] v);
        exp.push_back(v[7:0]);
        exp.push_back(v[15:8]);
    endfunction
    function automatic void hdr(input logic [15:0] id, input logic [15:0] len, input logic [15:0] tag);
        push16(id);
        push16(len);
        push16(tag);
    endfunction
    // Trailer over all queued bytes, MSB first, sent low byte first
    function automatic void push_crc();
        logic [15:0] c;
        c = CRC_INIT;
        foreach (exp[i]) begin
            c = c ^ {exp[i], 8'h00};
            for (int b = 0; b < 8; b++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        push16(c);
    endfunction
    function automatic void exp_ev(input dfr_event_type e, input logic pk);
        push16(pk ? 16'h000c + 16'(e.data_len) : 16'h0000);
        push16(e.source);
        for (int i = 0; i < 8; i++) exp.push_back(e.stamp[8*i+:8]);
        for (int i = 0; i < e.data_len; i++) exp.push_back(e.data[8*i+:8]);
    endfunction
    function automatic dfr_event_type rnd_ev(input logic [3:0] dl);
        seed = lfsr(seed);
        return '{data: {~seed, seed}, data_len: dl, stamp: {seed, lfsr(seed)}, source: seed[15:0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] d, input logic er);
        @(negedge core_clk);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge core_clk);
        rd_req = 1'b0;
        chk(32'(rd_q.valid), 32'h1);
        chk(32'({rd_q.err, rd_q.data}), 32'({er, d}));
    endtask
    // Random stalls meanwhile; a bounded wait stands for a hang
    task automatic get_pkt(input int extra);
        int n;
        n = 0;
        while (sink.pkts == seen && n < 3000) begin
            @(negedge core_clk);
            seed = lfsr(seed);
            stall = seed[0] & seed[1];
            n++;
        end
        stall = 1'b0;
        if (n >= 3000) begin
            num_errors++;
            summarize();
        end else begin
            seen++;
            chk(32'(sink.q.size() - base), 32'(exp.size() + extra));
            foreach (exp[i]) chk(32'(sink.q[base + i]), 32'(exp[i]));
            base = sink.q.size();
            exp.delete();
        end
    endtask
    task automatic send_ev(input dfr_event_type e);
        int n;
        n = 0;
        @(negedge core_clk);
        ev = e;
        ev_valid = 1'b1;
        @(posedge core_clk);
        while (ev_ready_q !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 200) begin
            num_errors++;
            summarize();
        end
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        rd(32'h0000_0007, 8'h00, 1'b0);
        rd(32'h0000_0043, 8'h00, 1'b0);
        rd(32'h0000_0004, 8'h61, 1'b0);
        rd(32'h0000_01c4, 8'h01, 1'b0);
        rd(32'h0000_01cc, 8'h03, 1'b0);
        rd(32'h0000_01d2, 8'h01, 1'b0);
        rd(32'h0000_01da, 8'h02, 1'b0);
        rd(32'h0001_0000, 8'h00, 1'b1);
        for (int k = 0; k < 4; k++) begin
            @(negedge core_clk);
            postfix_en = (k == 1);
            cfg_packed_en = (k >= 2);
            evs[0] = rnd_ev(k == 3 ? 4'h0 : 4'(seed % 9));
            evs[1] = rnd_ev(4'h8);
            send_ev(evs[0]);
            if (k == 2)
                send_ev(evs[1]);
            @(negedge core_clk);
            ev_valid = 1'b0;
            hdr(16'h0c00, 16'(12 + evs[0].data_len + (k == 2 ? 12 + evs[1].data_len : 0)), etag);
            exp_ev(evs[0], k >= 2);
            if (k == 2)
                exp_ev(evs[1], 1'b1);
            if (k == 1)
                push_crc();
            get_pkt(0);
            etag++;
        end
        @(negedge core_clk);
        max_resp_ms = 16'h0002;
        pend_timeout_ms = 16'h0009;
        cmd_tag = seed[15:0];
        cmd_start = 1'b1;
        @(negedge core_clk);
        cmd_start = 1'b0;
        for (int k = 0; k < 2; k++) begin
            hdr(16'h0805, 16'h0004, cmd_tag);
            push16(16'h0000);
            push16(pend_timeout_ms);
            if (k == 1) begin
                pend_req = 1'b1;
                @(negedge core_clk);
                pend_req = 1'b0;
            end
            get_pkt(0);
        end
        cmd_done = 1'b1;
        @(negedge core_clk);
        cmd_done = 1'b0;
        repeat (60) @(negedge core_clk);
        chk(32'(sink.pkts), 32'(seen));
        summarize();
    end
endmodule

// File: verilog/dfr_crc.sv
// CRC-16 over the bytes of one packet, MSB first.
// Assumes clear and feed never arrive in the same cycle.
`timescale 1ns/100ps
module dfr_crc
    import dfr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        clr,
    input  wire logic        feed,
    input  wire logic [7:0]  data_in,
    output logic      [15:0] crc_q
);

    logic [15:0] crc_d;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_comb begin
        crc_d = crc_q;
        if (clr) begin
            crc_d = CRC_INIT;
        end else if (feed) begin
            crc_d = crc_step(crc_q, data_in);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            crc_q <= CRC_INIT;
        end else if (ce) begin
            crc_q <= crc_d;
        end
    end

endmodule

// File: verilog/dfr_framer.sv
// Deferral reply and event packet framer with a small boot register read port.
// Assumes the byte sink, command tracker and event source share core_clk.
`timescale 1ns/100ps
module dfr_framer
    import dfr_pkg::*;
#(
    parameter int unsigned              PACK_DEPTH     = 4,
    parameter int unsigned              MS_CYCLES      = MS_CYCLES_DEF,
    parameter logic [15:0]              GUARD_MS       = 16'h0001,
    parameter logic                     PACKED_SUPPORT = 1'b1,
    parameter logic [3:0]               STR_ENC        = CAP_ENC_ASCII,
    parameter logic [8*STR_BYTES-1:0]   MFR_STR        = '0,
    parameter logic [6:0]               MFR_LEN        = 7'h00,
    parameter logic [8*STR_BYTES-1:0]   MODEL_STR      = '0,
    parameter logic [6:0]               MODEL_LEN      = 7'h00,
    parameter logic [63:0]              MANIFEST_PTR   = 64'h0000_0000_0001_0000,
    parameter logic [63:0]              TECH_BOOT_PTR  = 64'h0000_0000_0002_0000
)(
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    input  wire logic          ev_valid,
    input  wire dfr_event_type ev,
    output logic               ev_ready_q,
    output dfr_byte_type       tx_q,
    input  wire logic          tx_ready,
    input  wire logic          cfg_packed_en,
    input  wire logic          postfix_en,
    input  wire logic          cmd_start,
    input  wire logic [15:0]   cmd_tag,
    input  wire logic          cmd_done,
    input  wire logic          pend_req,
    input  wire logic [15:0]   pend_timeout_ms,
    input  wire logic [15:0]   max_resp_ms,
    input  wire logic          rd_req,
    input  wire logic [31:0]   rd_addr,
    output dfr_rd_type         rd_q
);

    localparam int unsigned IDX_W = (PACK_DEPTH > 1) ? $clog2(PACK_DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(PACK_DEPTH + 1);
    localparam int unsigned MS_W  = $clog2(MS_CYCLES + 1);

    dfr_state_type st_q, st_d;
    dfr_kind_type  kind_q, kind_d;
    dfr_event_type mem_q [PACK_DEPTH];
    dfr_event_type mem_d [PACK_DEPTH];
    dfr_byte_type  tx_d;
    dfr_rd_type    rd_d;
    logic [2:0]       pos_q, pos_d;
    logic [IDX_W-1:0] ev_idx_q, ev_idx_d;
    logic [4:0]       ev_pos_q, ev_pos_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [15:0]      plen_q, plen_d, ev_tag_q, ev_tag_d, cur_len;
    logic             packed_q, packed_d, post_q, post_d, ev_ready_d;
    logic             take, adv, def_go, crc_clr, crc_feed, packed_on, pay_end;
    logic [15:0]      crc_q;
    logic [47:0]      hdr;
    logic [31:0]      def_pay;
    logic [MS_W-1:0]  ms_q, ms_d;
    logic [15:0]      el_q, el_d, lim_q, lim_d, tag_q, tag_d;
    logic             act_q, act_d, pend_q, pend_d, overdue;

    function automatic logic [15:0] ev_len(input dfr_event_type e);
        return EV_FIXED_BYTES + 16'(e.data_len);
    endfunction

    function automatic logic [7:0] ev_byte(input dfr_event_type e, input logic pk, input logic [4:0] i);
        logic [8*(EV_DATA_OFS+EV_DATA_MAX)-1:0] v;
        v = {e.data, e.stamp, e.source, (pk ? ev_len(e) : 16'h0000)};
        return v[8*i +: 8];
    endfunction

    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] base, input logic [15:0] n);
        return (a >= base) && (a < base + n);
    endfunction

    function automatic logic [7:0] str_byte(input logic [8*STR_BYTES-1:0] s, input logic [6:0] n,
                                            input logic [5:0] i);
        return ({1'b0, i} < n) ? s[8*i +: 8] : 8'h00;
    endfunction

    function automatic logic [7:0] reg_byte(input logic [15:0] a);
        logic [63:0] cap;
        logic [31:0] mr;
        cap = '0;
        mr  = {16'h0000, max_resp_ms};
        cap[CAP_PACKED_BIT] = PACKED_SUPPORT;
        cap[CAP_ENC_LSB +: 4] = STR_ENC;
        if (in_rng(a, REG_MFR_NAME, 16'(STR_BYTES))) begin
            return str_byte(MFR_STR, MFR_LEN, 6'(a - REG_MFR_NAME));
        end else if (in_rng(a, REG_MODEL_NAME, 16'(STR_BYTES))) begin
            return str_byte(MODEL_STR, MODEL_LEN, 6'(a - REG_MODEL_NAME));
        end else if (in_rng(a, REG_CAP, 16'h0008)) begin
            return cap[8*(3'(a - REG_CAP)) +: 8];
        end else if (in_rng(a, REG_MAX_RESP, 16'h0004)) begin
            return mr[8*(2'(a - REG_MAX_RESP)) +: 8];
        end else if (in_rng(a, REG_MANIFEST, 16'h0008)) begin
            return MANIFEST_PTR[8*(3'(a - REG_MANIFEST)) +: 8];
        end else if (in_rng(a, REG_TECH_BOOT, 16'h0008)) begin
            return TECH_BOOT_PTR[8*(3'(a - REG_TECH_BOOT)) +: 8];
        end
        return 8'h00;
    endfunction

    // Framer
    always_comb begin
        st_d     = st_q;
        kind_d   = kind_q;
        mem_d    = mem_q;
        pos_d    = pos_q;
        ev_idx_d = ev_idx_q;
        ev_pos_d = ev_pos_q;
        cnt_d    = cnt_q;
        plen_d   = plen_q;
        ev_tag_d = ev_tag_q;
        packed_d = packed_q;
        post_d   = post_q;
        tx_d     = tx_q;
        def_go   = 1'b0;
        crc_clr  = 1'b0;
        crc_feed = 1'b0;
        pay_end  = 1'b0;
        packed_on = PACKED_SUPPORT && cfg_packed_en;
        take     = ev_valid && ev_ready_q;
        adv      = !tx_q.valid || tx_ready;
        cur_len  = ev_len(mem_q[ev_idx_q]);
        hdr      = {(kind_q == KIND_DEF) ? tag_q : ev_tag_q, plen_q,
                    (kind_q == KIND_DEF) ? CMD_PENDING_ACK : CMD_EVENT};
        def_pay  = {lim_q, DEF_RSV_VALUE};
        if (tx_q.valid && tx_ready) begin
            tx_d.valid = 1'b0;
        end
        case (st_q)
            ST_IDLE: begin
                if (take) begin
                    mem_d[0] = ev;
                    cnt_d    = CNT_W'(1);
                    plen_d   = ev_len(ev);
                    kind_d   = KIND_EVT;
                    packed_d = packed_on;
                    post_d   = postfix_en;
                    crc_clr  = 1'b1;
                    pos_d    = '0;
                    ev_idx_d = '0;
                    ev_pos_d = '0;
                    st_d     = packed_on ? ST_COLLECT : ST_HDR;
                end else if (pend_q) begin
                    kind_d  = KIND_DEF;
                    plen_d  = DEF_PAY_BYTES;
                    post_d  = postfix_en;
                    crc_clr = 1'b1;
                    pos_d   = '0;
                    def_go  = 1'b1;
                    st_d    = ST_HDR;
                end
            end
            ST_COLLECT: begin
                // Packing ends at the first idle cycle, so latency stays one beat
                if (take) begin
                    mem_d[IDX_W'(cnt_q)] = ev;
                    cnt_d  = cnt_q + CNT_W'(1);
                    plen_d = plen_q + ev_len(ev);
                    if (cnt_d == CNT_W'(PACK_DEPTH)) begin
                        st_d = ST_HDR;
                    end
                end else begin
                    st_d = ST_HDR;
                end
            end
            ST_HDR: begin
                if (adv) begin
                    tx_d     = '{valid: 1'b1, last: 1'b0, data: hdr[8*pos_q +: 8]};
                    crc_feed = 1'b1;
                    pos_d    = pos_q + 3'h1;
                    if (pos_q == 3'(HDR_BYTES - 1)) begin
                        pos_d = '0;
                        st_d  = ST_PAY;
                        if (kind_q == KIND_EVT) begin
                            ev_tag_d = ev_tag_q + 16'h0001;
                        end
                    end
                end
            end
            ST_PAY: begin
                if (adv) begin
                    crc_feed = 1'b1;
                    if (kind_q == KIND_DEF) begin
                        tx_d  = '{valid: 1'b1, last: 1'b0, data: def_pay[8*pos_q +: 8]};
                        pos_d = pos_q + 3'h1;
                        pay_end = (pos_q == 3'(DEF_PAY_BYTES - 16'h0001));
                    end else begin
                        tx_d = '{valid: 1'b1, last: 1'b0, data: ev_byte(mem_q[ev_idx_q], packed_q, ev_pos_q)};
                        ev_pos_d = ev_pos_q + 5'h01;
                        if (ev_pos_q == 5'(cur_len - 16'h0001)) begin
                            ev_pos_d = '0;
                            ev_idx_d = ev_idx_q + IDX_W'(1);
                            pay_end  = (CNT_W'(ev_idx_q) + CNT_W'(1)) == cnt_q;
                        end
                    end
                    if (pay_end) begin
                        pos_d     = '0;
                        tx_d.last = !post_q;
                        st_d      = post_q ? ST_POST : ST_IDLE;
                    end
                end
            end
            ST_POST: begin
                if (adv) begin
                    tx_d  = '{valid: 1'b1, last: 1'b0, data: crc_q[8*pos_q +: 8]};
                    pos_d = pos_q + 3'h1;
                    if (pos_q == 3'(POSTFIX_BYTES - 1)) begin
                        tx_d.last = 1'b1;
                        st_d      = ST_IDLE;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // A waiting deferral blocks new events in ST_IDLE so it cannot be starved; ST_COLLECT still takes them up to PACK_DEPTH
        ev_ready_d = ((st_d == ST_IDLE) && !pend_q && !def_go) ||
                     ((st_d == ST_COLLECT) && (cnt_d != CNT_W'(PACK_DEPTH)));
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_q       <= ST_IDLE;
            kind_q     <= KIND_DEF;
            pos_q      <= '0;
            ev_idx_q   <= '0;
            ev_pos_q   <= '0;
            cnt_q      <= '0;
            plen_q     <= '0;
            ev_tag_q   <= '0;
            packed_q   <= 1'b0;
            post_q     <= 1'b0;
            tx_q       <= '0;
            ev_ready_q <= 1'b0;
            for (int i = 0; i < PACK_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (ce) begin
            st_q       <= st_d;
            kind_q     <= kind_d;
            pos_q      <= pos_d;
            ev_idx_q   <= ev_idx_d;
            ev_pos_q   <= ev_pos_d;
            cnt_q      <= cnt_d;
            plen_q     <= plen_d;
            ev_tag_q   <= ev_tag_d;
            packed_q   <= packed_d;
            post_q     <= post_d;
            tx_q       <= tx_d;
            ev_ready_q <= ev_ready_d;
            mem_q      <= mem_d;
        end
    end

    // Deferral timer, one outstanding command
    always_comb begin
        ms_d    = ms_q;
        el_d    = el_q;
        lim_d   = lim_q;
        act_d   = act_q;
        tag_d   = tag_q;
        pend_d  = pend_q;
        overdue = act_q && ({1'b0, el_q} + {1'b0, GUARD_MS} >= {1'b0, lim_q});
        if (act_q) begin
            if (ms_q == MS_W'(MS_CYCLES - 1)) begin
                ms_d = '0;
                el_d = (el_q == 16'hffff) ? el_q : el_q + 16'h0001;
            end else begin
                ms_d = ms_q + MS_W'(1);
            end
        end
        if (def_go) begin
            // Host restarts its wait when the reply leaves; the local count restarts as the reply is started, before its first byte
            el_d   = '0;
            ms_d   = '0;
            lim_d  = pend_timeout_ms;
            pend_d = pend_req && act_q;
        end else if (overdue || (pend_req && act_q)) begin
            pend_d = 1'b1;
        end
        if (cmd_done) begin
            act_d  = 1'b0;
            pend_d = 1'b0;
        end
        if (cmd_start) begin
            act_d  = 1'b1;
            tag_d  = cmd_tag;
            el_d   = '0;
            ms_d   = '0;
            lim_d  = max_resp_ms;
            pend_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ms_q   <= '0;
            el_q   <= '0;
            lim_q  <= '0;
            act_q  <= 1'b0;
            tag_q  <= '0;
            pend_q <= 1'b0;
        end else if (ce) begin
            ms_q   <= ms_d;
            el_q   <= el_d;
            lim_q  <= lim_d;
            act_q  <= act_d;
            tag_q  <= tag_d;
            pend_q <= pend_d;
        end
    end

    // Boot register read port, one byte per request
    always_comb begin
        rd_d.valid = rd_req;
        rd_d.err   = rd_req && (rd_addr[31:BOOT_ADDR_BITS] != '0);
        rd_d.data  = (rd_req && !rd_d.err) ? reg_byte(rd_addr[BOOT_ADDR_BITS-1:0]) : 8'h00;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rd_q <= '0;
        end else if (ce) begin
            rd_q <= rd_d;
        end
    end

    dfr_crc u_crc (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .clr      (crc_clr),
        .feed     (crc_feed && ce),
        .data_in  (tx_d.data),
        .crc_q    (crc_q)
    );

    sequence s_def_hdr0;
        ce && adv && (st_q == ST_HDR) && (pos_q == 3'h0) && (kind_q == KIND_DEF);
    endsequence
    property p_ack_lsb;
        @(posedge core_clk) disable iff (!rst_b) s_def_hdr0 |=> tx_q.valid && tx_q.data[0];
    endproperty
    a_ack_lsb: assert property (p_ack_lsb) else $error("deferral id low bit clear");

    property p_def_rsv;
        @(posedge core_clk) disable iff (!rst_b)
            ce && adv && (st_q == ST_PAY) && (kind_q == KIND_DEF) && (pos_q < 3'h2) |=> tx_q.data == 8'h00;
    endproperty
    a_def_rsv: assert property (p_def_rsv) else $error("deferral reserved byte not zero");

    property p_def_tmo;
        @(posedge core_clk) disable iff (!rst_b)
            ce && adv && (st_q == ST_PAY) && (kind_q == KIND_DEF) && (pos_q == 3'h2) |=> tx_q.data == lim_q[7:0];
    endproperty
    a_def_tmo: assert property (p_def_tmo) else $error("deferral timeout byte wrong");

    property p_rearm;
        @(posedge core_clk) disable iff (!rst_b)
            ce && def_go && !cmd_start && !cmd_done |=> (el_q == 16'h0000) && (lim_q == $past(pend_timeout_ms));
    endproperty
    a_rearm: assert property (p_rearm) else $error("deferral did not re-arm timer");

    property p_overdue;
        @(posedge core_clk) disable iff (!rst_b)
            ce && overdue && !def_go && !cmd_done && !cmd_start |=> pend_q;
    endproperty
    a_overdue: assert property (p_overdue) else $error("overdue command without deferral");

    sequence s_ev_len_byte;
        ce && adv && (st_q == ST_PAY) && (kind_q == KIND_EVT) && (ev_pos_q == 5'h00);
    endsequence
    property p_unpacked_len;
        @(posedge core_clk) disable iff (!rst_b) (s_ev_len_byte and !packed_q) |=> tx_q.data == 8'h00;
    endproperty
    a_unpacked_len: assert property (p_unpacked_len) else $error("unpacked length field not zero");

    property p_len12;
        @(posedge core_clk) disable iff (!rst_b)
            (s_ev_len_byte and (packed_q && (mem_q[ev_idx_q].data_len == 4'h0))) |=> tx_q.data == 8'h0c;
    endproperty
    a_len12: assert property (p_len12) else $error("bare packed event length not twelve");

    property p_single;
        @(posedge core_clk) disable iff (!rst_b)
            (st_q == ST_HDR) && (kind_q == KIND_EVT) && packed_q && (cnt_q == CNT_W'(1))
            |-> plen_q == ev_len(mem_q[0]);
    endproperty
    a_single: assert property (p_single) else $error("single packed event length mismatch");

    property p_adjacent;
        @(posedge core_clk) disable iff (!rst_b)
            ce && adv && (st_q == ST_PAY) && (kind_q == KIND_EVT) && (ev_pos_q == 5'(cur_len - 16'h0001))
            && ((CNT_W'(ev_idx_q) + CNT_W'(1)) != cnt_q)
            |=> (ev_pos_q == 5'h00) && (ev_idx_q == IDX_W'($past(ev_idx_q) + IDX_W'(1))) && (st_q == ST_PAY);
    endproperty
    a_adjacent: assert property (p_adjacent) else $error("next event not adjacent");

    property p_boot;
        @(posedge core_clk) disable iff (!rst_b)
            ce && rd_req |=> rd_q.valid && (rd_q.err == ($past(rd_addr[31:BOOT_ADDR_BITS]) != '0));
    endproperty
    a_boot: assert property (p_boot) else $error("boot space decode wrong");

endmodule

// File: verilog/dfr_pkg.sv
// Constants and carrier types for the deferral and event packet framer.
// Assumes one 20 MHz core clock shared by every user of this package.
package dfr_pkg;

    // Clock and millisecond tick
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam int unsigned MS_TIME       = 1;
    localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S * MS_TIME;

    // Command identifiers, acknowledge codes are odd
    localparam logic [15:0] CMD_PENDING_ACK = 16'h0805;
    localparam logic [15:0] CMD_EVENT       = 16'h0c00;

    // Packet layout in bytes
    localparam int unsigned HDR_BYTES      = 6;
    localparam logic [15:0] DEF_PAY_BYTES  = 16'h0004;
    localparam int unsigned DEF_RSV_OFS    = 0;
    localparam int unsigned DEF_TMO_OFS    = 2;
    localparam logic [15:0] DEF_RSV_VALUE  = 16'h0000;
    localparam logic [15:0] EV_FIXED_BYTES = 16'h000c;
    localparam int unsigned EV_LEN_OFS     = 0;
    localparam int unsigned EV_SRC_OFS     = 2;
    localparam int unsigned EV_TS_OFS      = 4;
    localparam int unsigned EV_DATA_OFS    = 12;
    localparam int unsigned EV_DATA_MAX    = 8;
    localparam int unsigned POSTFIX_BYTES  = 2;
    localparam logic [15:0] CRC_INIT       = 16'hffff;
    localparam logic [15:0] CRC_POLY       = 16'h1021;

    // Generic boot register space
    localparam int unsigned BOOT_ADDR_BITS = 16;
    localparam int unsigned STR_BYTES      = 64;
    localparam logic [15:0] REG_MFR_NAME   = 16'h0004;
    localparam logic [15:0] REG_MODEL_NAME = 16'h0044;
    localparam logic [15:0] REG_CAP        = 16'h01c4;
    localparam logic [15:0] REG_MAX_RESP   = 16'h01cc;
    localparam logic [15:0] REG_MANIFEST   = 16'h01d0;
    localparam logic [15:0] REG_TECH_BOOT  = 16'h01d8;
    localparam int unsigned CAP_PACKED_BIT = 0;
    localparam int unsigned CAP_ENC_LSB    = 4;
    localparam logic [3:0]  CAP_ENC_ASCII  = 4'h0;

    typedef struct packed {
        logic [8*EV_DATA_MAX-1:0] data;
        logic [3:0]               data_len;
        logic [63:0]              stamp;
        logic [15:0]              source;
    } dfr_event_type;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } dfr_byte_type;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] data;
    } dfr_rd_type;

    typedef enum logic {KIND_DEF, KIND_EVT} dfr_kind_type;

    typedef enum {ST_IDLE, ST_COLLECT, ST_HDR, ST_PAY, ST_POST} dfr_state_type;

endpackage
